// ---- design/lock_detect_defines.svh ----
`ifndef LOCK_DETECT_DEFINES_SVH
`define LOCK_DETECT_DEFINES_SVH

// ==========================================================
// Register addresses
`define ADDR_ID_STROBE 6'h00
`define ADDR_EN_RESET 6'h01
`define ADDR_LKD_CFG 6'h1A
`define ADDR_GPO_CTRL 6'h1B
`define ADDR_STATUS 6'h1F

// ==========================================================
// Reset values
`define EN_RESET_DEFAULT 16'hDF7F
`define LKD_CFG_DEFAULT 20'h7912A
`define GPO_CTRL_DEFAULT 4'h0

// ==========================================================
// Field positions
`define STB_SWRST_REGS 0
`define STB_SWRST_DIG 1
`define STB_TEMP 3
`define EN_LKD 11
`define EN_PUMP 12
`define EN_DSM 13
`define LKD_THR_MSB 9
`define LKD_ASYM_EN 10
`define LKD_ASYM_UP 11
`define LKD_AUTOMUX 12
`define LKD_ALWAYS 13
`define LKD_RO_SEL 14
`define LKD_RO_CFG_MSB 16
`define LKD_RO_CFG_LSB 15
`define LKD_DUR_MSB 18
`define LKD_DUR_LSB 17
`define LKD_RO_TEST 19
`define STATUS_LOCK 0
`define GPO_SEL_RO_TEST 4'h7

// ==========================================================
// Frame and timing
`define ADDR_LAST_CNT 5'h05
`define DATA_LAST_CNT 5'h17
`define CLK_PERIOD_NS 8
`define ANALOG_WIN_NS 10
`define ANALOG_WIN_CYC ((`ANALOG_WIN_NS / `CLK_PERIOD_NS) < 1 ? 1 : (`ANALOG_WIN_NS / `CLK_PERIOD_NS))
`define RO_BASE_CYC 2
`define CNT_SAT 9'h1FF

`endif

// ---- design/lock_detect_pkg.sv ----
package lock_detect_pkg;
  typedef enum logic [1:0] {fr_idle, fr_addr, fr_data, fr_done} frame_state_t;
endpackage

// ---- design/lkd_if.sv ----
`timescale 1ns/1ps
interface lkd_if;
  logic enable;
  logic ro_test;
  logic ro_sel;
  logic asym_en;
  logic asym_up;
  logic [1:0] ro_cfg;
  logic [1:0] duration;
  logic [9:0] threshold;
  logic locked;
  logic ro_clk;
  modport ctrl (output enable, ro_test, ro_sel, asym_en, asym_up, ro_cfg, duration, threshold, input locked, ro_clk);
  modport detector (input enable, ro_test, ro_sel, asym_en, asym_up, ro_cfg, duration, threshold,
                    output locked, ro_clk);
endinterface

// ---- design/lock_window_detect.sv ----
`timescale 1ns/1ps
`include "lock_detect_defines.svh"
module lock_window_detect (
  input wire logic sys_clk, // System clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic ref_lvl, // Synchronised reference level
  input wire logic vco_lvl, // Synchronised divided VCO level
  lkd_if.detector lk // Configuration and lock result
);
  logic ref_d_reg, vco_d_reg, judged_reg, locked_reg, ro_out_reg;
  logic [8:0] since_ref_reg, since_vco_reg;
  logic [9:0] hits_reg;
  logic [2:0] ro_cnt_reg;

  // ==========================================================
  // Window geometry
  wire ref_edge = ref_lvl & ~ref_d_reg;
  wire vco_edge = vco_lvl & ~vco_d_reg;
  wire active = lk.enable & ~lk.ro_test;
  // Larger codes give a slower oscillator and a longer window
  wire [2:0] ro_half = 3'((32'(lk.ro_cfg) + 1) * `RO_BASE_CYC - 1);
  wire [8:0] dig_half = 9'((32'(lk.duration) + 1) * (32'(lk.ro_cfg) + 1) * `RO_BASE_CYC);
  wire [8:0] win_half = lk.ro_sel ? dig_half : 9'(`ANALOG_WIN_CYC);
  wire [8:0] win_full = {win_half[7:0], 1'b0};
  wire [8:0] win_before = lk.asym_en ? (lk.asym_up ? 9'h000 : win_full) : win_half;
  wire [8:0] win_after = lk.asym_en ? (lk.asym_up ? win_full : 9'h000) : win_half;
  wire hit_pre = ref_edge & (vco_edge | (since_vco_reg < win_before));
  wire hit_post = ~judged_reg & ~ref_edge & vco_edge & (since_ref_reg < win_after);
  wire miss = ~judged_reg & ~ref_edge & ~hit_post & (since_ref_reg >= win_after);
  wire hit = hit_pre | hit_post;
  wire reach = (10'(hits_reg + 10'h001) >= lk.threshold);

  assign lk.locked = locked_reg;
  assign lk.ro_clk = ro_out_reg;

  // ==========================================================
  // Ring oscillator model
  always_ff @(posedge sys_clk) begin
    if (!nrst || !(lk.ro_sel || lk.ro_test)) begin
      ro_cnt_reg <= 3'h0;
      ro_out_reg <= 1'b0;
    end else if (ro_cnt_reg >= ro_half) begin
      ro_cnt_reg <= 3'h0;
      ro_out_reg <= ~ro_out_reg;
    end else begin
      ro_cnt_reg <= ro_cnt_reg + 3'h1;
    end
  end

  // ==========================================================
  // Edge timers
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ref_d_reg <= 1'b0;
      vco_d_reg <= 1'b0;
      since_ref_reg <= `CNT_SAT;
      since_vco_reg <= `CNT_SAT;
    end else begin
      ref_d_reg <= ref_lvl;
      vco_d_reg <= vco_lvl;
      since_ref_reg <= ref_edge ? 9'h000 : (since_ref_reg == `CNT_SAT ? `CNT_SAT : since_ref_reg + 9'h001);
      since_vco_reg <= vco_edge ? 9'h000 : (since_vco_reg == `CNT_SAT ? `CNT_SAT : since_vco_reg + 9'h001);
    end
  end

  // ==========================================================
  // Consecutive hit counter and lock flag
  always_ff @(posedge sys_clk) begin
    if (!nrst || !active) begin
      judged_reg <= 1'b1;
      hits_reg <= 10'h000;
      locked_reg <= 1'b0;
    end else begin
      if (ref_edge) judged_reg <= hit_pre;
      else if (hit_post || miss) judged_reg <= 1'b1;
      if (miss) begin
        hits_reg <= 10'h000;
        locked_reg <= 1'b0;
      end else if (hit) begin
        if (!reach) hits_reg <= hits_reg + 10'h001;
        if (reach) locked_reg <= 1'b1;
      end
    end
  end

  AST_MISS_CLEARS: assert property (@(posedge sys_clk) disable iff (!nrst) active && miss |=> !locked_reg)
    else $error("lock flag survived a miss");
  AST_MISS_RESTARTS: assert property (@(posedge sys_clk) disable iff (!nrst) active && miss |=> hits_reg == 10'h000)
    else $error("hit count not restarted by a miss");
  AST_LOCK_AT_COUNT: assert property (@(posedge sys_clk) disable iff (!nrst)
    active && hit && !miss && reach ##1 active |-> locked_reg) else $error("lock not set at threshold");
  AST_NO_EARLY_LOCK: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(locked_reg) |-> $past(reach) && $past(hit)) else $error("lock set before threshold");
  AST_DISABLED: assert property (@(posedge sys_clk) disable iff (!nrst) !active |=> !locked_reg && hits_reg == 10'h000)
    else $error("detector active while disabled");
  COV_LOCK: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(locked_reg));
  COV_UNLOCK: cover property (@(posedge sys_clk) disable iff (!nrst) locked_reg && miss);
endmodule // lock_window_detect

// ---- design/pll_lock_detect_unit.sv ----
`timescale 1ns/1ps
`include "lock_detect_defines.svh"
// Overview of operation
// - Lock detection runs only while enable-and-reset bit 11 is set.
// - Bit 11 is an active-low reset for detector and pin gating, default 1.
// - Window source bit clear selects fixed window of about 10 ns each side.
// - Window source bit set selects a ring-oscillator timed window.
// - Ring oscillator speed comes from field bits 16 to 15.
// - Code 0 is fastest and shortest, code 3 slowest and longest.
// - Digital window length is duration field bits 18 to 17, plus one, oscillator periods.
// - Test bit 19 with output select 0111 shows oscillator; lock detect stops.
// - Lock declared after threshold consecutive in-window arrivals, field bits 9 to 0.
// - Reaching threshold sets lock flag at status register 1Fh bit 0.
// - Any arrival outside the window clears the lock flag at once.
// - Lock flag is read-only over the serial port; writes ignored.
// - Always-route bit 13 puts lock flag on pin; reads are impossible.
// - Auto-mux bit 12 shows lock except during a serial read.
// - Auto-mux switches to data out when read is sensed on first edge.
// - Asymmetric enable and polarity set place the window after reference.
// - Asymmetric enable with polarity clear places the window before reference.
// - Reading address 00h returns a 24-bit identity code.
// - Write 00h bit 0 resets registers; bit 1 resets remaining digital logic.
// - Write 00h bit 3 triggers one temperature measurement.
// - Clearing enable bit 12 puts the charge pump output in high impedance.
// - Modulator runs only while enable bit 13 is set, default 0.
module pll_lock_detect_unit
  import lock_detect_pkg::*;
#(
  parameter logic [23:0] ID_CODE = 24'h5A3C01 // Arbitrary identity value
) (
  input wire logic sys_clk, // System clock, 125 MHz
  input wire logic nrst, // Synchronous reset, active low
  input wire logic ref_in, // Reference clock pin
  input wire logic vco_div_in, // Divided VCO pin
  input wire logic sen, // Serial enable, active high
  input wire logic sck, // Serial clock pin
  input wire logic sdi, // Serial data in
  output logic lock_indicator_pin, // Shared lock / serial data out pin
  output logic general_output_2, // Second general output
  output logic pump_enable, // Charge pump drive enable, low is high-Z
  output logic modulator_run, // Fractional modulator out of reset
  output logic soft_dig_reset, // One-cycle digital soft reset pulse
  output logic temp_measure_strobe // One-cycle temperature measure pulse
);
  // ==========================================================
  // Pin synchronisers
  // Bit order: ref, vco, sen, sck, sdi
  logic [4:0] pin_s1_reg, pin_s2_reg;
  logic sck_d_reg;
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pin_s1_reg <= 5'h00;
      pin_s2_reg <= 5'h00;
      sck_d_reg <= 1'b0;
    end else begin
      pin_s1_reg <= {ref_in, vco_div_in, sen, sck, sdi};
      pin_s2_reg <= pin_s1_reg;
      sck_d_reg <= pin_s2_reg[1];
    end
  end
  wire ref_lvl = pin_s2_reg[4];
  wire vco_lvl = pin_s2_reg[3];
  wire sen_lvl = pin_s2_reg[2];
  wire sdi_lvl = pin_s2_reg[0];
  // Oversampling limits the serial clock to well under a quarter of sys_clk
  wire sck_rise = sen_lvl & pin_s2_reg[1] & ~sck_d_reg;

  // ==========================================================
  // Serial frame decoder
  frame_state_t state_reg, state_next;
  logic is_read_reg;
  logic [4:0] cnt_reg;
  logic [5:0] addr_reg;
  logic [23:0] shift_reg;
  logic sdo_reg;
  logic [15:0] en_reset_reg;
  logic [19:0] lkd_cfg_reg;
  logic [3:0] gpo_ctrl_reg;
  logic pin_reg, general_output_2_reg, soft_dig_reg, temp_reg;

  wire [5:0] addr_full = {addr_reg[4:0], sdi_lvl};
  wire [23:0] wr_data = {shift_reg[22:0], sdi_lvl};
  wire pin_always = lkd_cfg_reg[`LKD_ALWAYS];
  wire pin_auto_share_en = lkd_cfg_reg[`LKD_AUTOMUX];
  wire addr_done = (state_reg == fr_addr) & sck_rise & (cnt_reg == `ADDR_LAST_CNT);
  wire data_done = (state_reg == fr_data) & sck_rise & (cnt_reg == `DATA_LAST_CNT);
  wire wr_commit = data_done & ~is_read_reg;
  wire strobe_wr = wr_commit & (addr_reg == `ADDR_ID_STROBE);
  wire swrst_regs = strobe_wr & wr_data[`STB_SWRST_REGS];
  wire swrst_dig = strobe_wr & wr_data[`STB_SWRST_DIG];
  wire temp_go = strobe_wr & wr_data[`STB_TEMP];
  // Read sensed on first edge; always-route mode refuses reads
  wire read_active = is_read_reg & ~pin_always & (state_reg != fr_idle);
  wire locked_flag;

  always_comb begin
    state_next = state_reg;
    if (!sen_lvl) begin
      state_next = fr_idle;
    end else if (sck_rise) begin
      unique case (state_reg)
        fr_idle: state_next = fr_addr;
        fr_addr: state_next = addr_done ? fr_data : fr_addr;
        fr_data: state_next = data_done ? fr_done : fr_data;
        fr_done: state_next = fr_done;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_reg <= fr_idle;
      cnt_reg <= 5'h00;
      is_read_reg <= 1'b0;
      addr_reg <= 6'h00;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg || !sen_lvl) cnt_reg <= 5'h00;
      else if (sck_rise) cnt_reg <= cnt_reg + 5'h01;
      if (state_reg == fr_idle && sck_rise) is_read_reg <= sdi_lvl;
      if (state_reg == fr_addr && sck_rise) addr_reg <= addr_full;
    end
  end

  // ==========================================================
  // Read data selection
  logic [23:0] rd_data;
  always_comb begin
    unique case (addr_full)
      `ADDR_ID_STROBE: rd_data = ID_CODE;
      `ADDR_EN_RESET: rd_data = {8'h00, en_reset_reg};
      `ADDR_LKD_CFG: rd_data = {4'h0, lkd_cfg_reg};
      `ADDR_GPO_CTRL: rd_data = {20'h00000, gpo_ctrl_reg};
      `ADDR_STATUS: rd_data = {23'h000000, locked_flag};
      default: rd_data = 24'h000000;
    endcase
  end

  // Data bits leave MSB first on rising edges after the address
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      shift_reg <= 24'h000000;
      sdo_reg <= 1'b0;
    end else if (addr_done) begin
      shift_reg <= rd_data;
    end else if (state_reg == fr_data && sck_rise) begin
      if (is_read_reg) begin
        sdo_reg <= shift_reg[23];
        shift_reg <= {shift_reg[22:0], 1'b0};
      end else begin
        shift_reg <= wr_data;
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge sys_clk) begin
    if (!nrst || swrst_regs) begin
      en_reset_reg <= `EN_RESET_DEFAULT;
      lkd_cfg_reg <= `LKD_CFG_DEFAULT;
      gpo_ctrl_reg <= `GPO_CTRL_DEFAULT;
    end else if (wr_commit) begin
      // Status address is not decoded for writes: lock flag stays hardware-owned
      if (addr_reg == `ADDR_EN_RESET) en_reset_reg <= wr_data[15:0];
      if (addr_reg == `ADDR_LKD_CFG) lkd_cfg_reg <= wr_data[19:0];
      if (addr_reg == `ADDR_GPO_CTRL) gpo_ctrl_reg <= wr_data[3:0];
    end
  end

  // ==========================================================
  // Lock detector
  lkd_if lk ();
  assign lk.enable = en_reset_reg[`EN_LKD] & ~soft_dig_reg;
  assign lk.ro_test = lkd_cfg_reg[`LKD_RO_TEST];
  assign lk.ro_sel = lkd_cfg_reg[`LKD_RO_SEL];
  assign lk.asym_en = lkd_cfg_reg[`LKD_ASYM_EN];
  assign lk.asym_up = lkd_cfg_reg[`LKD_ASYM_UP];
  assign lk.ro_cfg = lkd_cfg_reg[`LKD_RO_CFG_MSB:`LKD_RO_CFG_LSB];
  assign lk.duration = lkd_cfg_reg[`LKD_DUR_MSB:`LKD_DUR_LSB];
  assign lk.threshold = lkd_cfg_reg[`LKD_THR_MSB:0];
  assign locked_flag = lk.locked;

  lock_window_detect u_detect (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ref_lvl(ref_lvl),
    .vco_lvl(vco_lvl),
    .lk(lk)
  );

  // ==========================================================
  // Output pins
  wire pin_next = pin_always ? locked_flag :
                  (pin_auto_share_en & ~read_active) ? locked_flag : sdo_reg;
  // Lock gating sits behind the same enable as the detector
  wire pin_gated = pin_next & (read_active | ~pin_auto_share_en | en_reset_reg[`EN_LKD]);
  wire gpo_ro = lk.ro_test & (gpo_ctrl_reg == `GPO_SEL_RO_TEST);

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pin_reg <= 1'b0;
      general_output_2_reg <= 1'b0;
      soft_dig_reg <= 1'b0;
      temp_reg <= 1'b0;
    end else begin
      pin_reg <= pin_gated;
      general_output_2_reg <= gpo_ro & lk.ro_clk;
      soft_dig_reg <= swrst_dig;
      temp_reg <= temp_go;
    end
  end

  assign lock_indicator_pin = pin_reg;
  assign general_output_2 = general_output_2_reg;
  assign pump_enable = en_reset_reg[`EN_PUMP];
  assign modulator_run = en_reset_reg[`EN_DSM];
  assign soft_dig_reset = soft_dig_reg;
  assign temp_measure_strobe = temp_reg;

  // ==========================================================
  // Checks
  AST_STROBE_ONE_CYCLE: assert property (@(posedge sys_clk) disable iff (!nrst)
    temp_measure_strobe |=> !temp_measure_strobe) else $error("temperature strobe held");
  AST_TEMP_CAUSE: assert property (@(posedge sys_clk) disable iff (!nrst)
    temp_measure_strobe |-> $past(temp_go)) else $error("temperature strobe without write");
  AST_DIG_RESET_DETECTOR: assert property (@(posedge sys_clk) disable iff (!nrst)
    swrst_dig |=> ##1 !locked_flag) else $error("digital soft reset left lock set");
  AST_PIN_ALWAYS: assert property (@(posedge sys_clk) disable iff (!nrst)
    pin_always && en_reset_reg[`EN_LKD] && $stable(pin_always) |=> lock_indicator_pin == $past(locked_flag))
    else $error("pin does not follow lock in always mode");
  AST_AUTOMUX_LOCK: assert property (@(posedge sys_clk) disable iff (!nrst)
    !pin_always && pin_auto_share_en && !read_active && en_reset_reg[`EN_LKD]
    |=> lock_indicator_pin == $past(locked_flag)) else $error("auto-mux pin not showing lock");
  AST_AUTOMUX_READ: assert property (@(posedge sys_clk) disable iff (!nrst)
    read_active && !pin_always |=> lock_indicator_pin == $past(sdo_reg)) else $error("pin not serving read data");
  AST_STATUS_WRITE_IGNORED: assert property (@(posedge sys_clk) disable iff (!nrst)
    wr_commit && addr_reg == `ADDR_STATUS |=> $stable(en_reset_reg) && $stable(lkd_cfg_reg) && $stable(gpo_ctrl_reg))
    else $error("status write altered a register");
  AST_REG_SOFT_RESET: assert property (@(posedge sys_clk) disable iff (!nrst)
    swrst_regs |=> en_reset_reg == `EN_RESET_DEFAULT && lkd_cfg_reg == `LKD_CFG_DEFAULT)
    else $error("register soft reset missed");
  AST_MOD_RUN: assert property (@(posedge sys_clk) disable iff (!nrst)
    wr_commit && addr_reg == `ADDR_EN_RESET && !swrst_regs |=> modulator_run == $past(wr_data[`EN_DSM]))
    else $error("modulator run not following bit 13");
  AST_PUMP: assert property (@(posedge sys_clk) disable iff (!nrst)
    wr_commit && addr_reg == `ADDR_EN_RESET |=> pump_enable == $past(wr_data[`EN_PUMP]))
    else $error("pump enable not following bit 12");
  AST_RO_TEST_STOPS: assert property (@(posedge sys_clk) disable iff (!nrst)
    lk.ro_test |=> !locked_flag) else $error("lock detect ran in test mode");

  COV_READ_FRAME: cover property (@(posedge sys_clk) disable iff (!nrst) data_done && is_read_reg);
  COV_WRITE_FRAME: cover property (@(posedge sys_clk) disable iff (!nrst) wr_commit && addr_reg == `ADDR_LKD_CFG);
  COV_STROBE: cover property (@(posedge sys_clk) disable iff (!nrst) temp_go);
endmodule // pll_lock_detect_unit

// ---- bench/serial_host.sv ----
`timescale 1ns/1ps
// ==========================================================
// Serial host: sends whole frames, samples the shared pin
module serial_host #(
  parameter int PH = 6 // Cycles per high phase (low phase is twice that), above the 5-cycle minimum for reads
) (
  input wire logic sys_clk, // System clock
  input wire logic pin, // Shared lock / data out pin
  output logic sen, // Serial enable
  output logic sck, // Serial clock, still outside frames
  output logic sdi // Serial data in
);
  initial begin
    sen = 1'b0;
    sck = 1'b0;
    sdi = 1'b0;
  end

  // Sampled late in the high phase, as read data lags the edge by cycles
  task automatic frame(input logic rd, input logic [5:0] addr, input logic [23:0] wdat, output logic [23:0] rdat);
    logic [30:0] bits;
    bits = {rd, addr, wdat};
    rdat = 24'h000000;
    @(posedge sys_clk);
    sen <= 1'b1;
    for (int i = 30; i >= 0; i--) begin
      repeat (PH) @(posedge sys_clk);
      sdi <= bits[i];
      repeat (PH) @(posedge sys_clk);
      sck <= 1'b1;
      repeat (PH) @(posedge sys_clk);
      rdat = {rdat[22:0], pin};
      sck <= 1'b0;
    end
    repeat (PH) @(posedge sys_clk);
    sen <= 1'b0;
    // Released line shows the inverse, never a stale copy
    sdi <= ~sdi;
    repeat (2 * PH) @(posedge sys_clk);
  endtask
endmodule // serial_host

// ---- bench/tb.sv ----
`timescale 1ns/1ps
`include "lock_detect_defines.svh"
module tb;
  localparam logic [23:0] ID = 24'h3C5A96; // Arbitrary identity value
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic ref_in = 1'b0;
  logic vco_div_in = 1'b0;
  logic sen, sck, sdi, lock_indicator_pin, general_output_2;
  logic pump_enable, modulator_run, soft_dig_reset, temp_measure_strobe;
  logic gpo_q = 1'b0;
  logic [23:0] rdat;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  int n_temp = 0;
  int n_sdr = 0;
  int n_gpo = 0;
  int g0;

  pll_lock_detect_unit #(.ID_CODE(ID)) u_dut (.sys_clk(sys_clk), .nrst(nrst), .ref_in(ref_in),
    .vco_div_in(vco_div_in), .sen(sen), .sck(sck), .sdi(sdi), .lock_indicator_pin(lock_indicator_pin),
    .general_output_2(general_output_2), .pump_enable(pump_enable), .modulator_run(modulator_run),
    .soft_dig_reset(soft_dig_reset), .temp_measure_strobe(temp_measure_strobe));
  serial_host #(.PH(6)) u_host (.sys_clk(sys_clk), .pin(lock_indicator_pin), .sen(sen), .sck(sck), .sdi(sdi));

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Pulse and toggle counters, timeout
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    n_temp <= n_temp + int'(temp_measure_strobe);
    n_sdr <= n_sdr + int'(soft_dig_reset);
    gpo_q <= general_output_2;
    n_gpo <= n_gpo + int'(gpo_q != general_output_2);
    if (cyc == 90000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // ==========================================================
  // Tasks
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    u_host.frame(1'b0, a, d, rdat);
  endtask

  task automatic rd_chk(input string what, input logic [5:0] a, input logic [23:0] exp);
    u_host.frame(1'b1, a, 24'h000000, rdat);
    check(what, rdat, exp);
  endtask

  task automatic pin_chk(input logic exp);
    check("lock pin", 24'(lock_indicator_pin), 24'(exp));
  endtask

  // Vco edge lands d cycles after the reference edge, period 80 cycles
  task automatic pulses(input int n, input int d);
    for (int k = 0; k < n; k++) begin
      for (int i = 0; i < 80; i++) begin
        @(posedge sys_clk);
        ref_in <= (i >= 20 && i < 50);
        vco_div_in <= (i >= 20 + d && i < 50 + d);
      end
    end
    repeat (8) @(posedge sys_clk);
  endtask

  // A miss first, so any lock below comes from four fresh hits
  task automatic trial(input logic [23:0] cfg, input int d, input logic exp);
    wr(`ADDR_LKD_CFG, cfg);
    pulses(1, 30);
    pulses(4, d);
    pin_chk(exp);
  endtask

  task automatic done(input string t);
    $display("test %s finished", t);
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check("pump enable", 24'(pump_enable), 24'h000001);
    check("modulator run", 24'(modulator_run), 24'h000000);
    rd_chk("enable reg", `ADDR_EN_RESET, 24'h00DF7F);
    rd_chk("identity", `ADDR_ID_STROBE, ID);
    rd_chk("lock cfg", `ADDR_LKD_CFG, 24'h07912A);
    rd_chk("unmapped", 6'h05, 24'h000000);
    done("defaults");
    wr(`ADDR_LKD_CFG, 24'h079004);
    pulses(1, 30);
    pulses(3, 0);
    pin_chk(1'b0);
    pulses(1, 0);
    pin_chk(1'b1);
    rd_chk("status", `ADDR_STATUS, 24'h000001);
    pin_chk(1'b1);
    wr(`ADDR_STATUS, 24'h000000);
    rd_chk("status kept", `ADDR_STATUS, 24'h000001);
    done("lock");
    pulses(1, 30);
    pin_chk(1'b0);
    pulses(3, 0);
    pin_chk(1'b0);
    pulses(1, 0);
    pin_chk(1'b1);
    wr(`ADDR_LKD_CFG, 24'h07B004);
    rd_chk("read blocked", `ADDR_EN_RESET, 24'hFFFFFF);
    done("miss and route");
    trial(24'h079004, 1, 1'b1);
    trial(24'h079004, 2, 1'b0);
    trial(24'h005004, 2, 1'b1);
    trial(24'h005004, 3, 1'b0);
    trial(24'h00D004, 4, 1'b1);
    trial(24'h00D004, 5, 1'b0);
    trial(24'h025004, 4, 1'b1);
    trial(24'h005C04, 4, 1'b1);
    trial(24'h005C04, -1, 1'b0);
    trial(24'h005404, -4, 1'b1);
    trial(24'h005404, 1, 1'b0);
    done("windows");
    wr(`ADDR_LKD_CFG, 24'h079004);
    wr(`ADDR_EN_RESET, 24'h00D77F);
    pulses(5, 0);
    rd_chk("status off", `ADDR_STATUS, 24'h000000);
    wr(`ADDR_EN_RESET, 24'h00DF7F);
    pulses(4, 0);
    pin_chk(1'b1);
    wr(`ADDR_GPO_CTRL, 24'h000007);
    wr(`ADDR_LKD_CFG, 24'h0F9004);
    g0 = n_gpo;
    pulses(5, 0);
    check("ring toggles", 24'(n_gpo - g0 > 10), 24'h000001);
    rd_chk("status test", `ADDR_STATUS, 24'h000000);
    done("enable and test");
    wr(`ADDR_EN_RESET, 24'h00EF7F);
    check("pump off", 24'(pump_enable), 24'h000000);
    check("modulator on", 24'(modulator_run), 24'h000001);
    rd_chk("enable back", `ADDR_EN_RESET, 24'h00EF7F);
    g0 = n_sdr;
    wr(`ADDR_ID_STROBE, 24'h000008);
    check("temp pulses", 24'(n_temp), 24'h000001);
    check("no dig reset", 24'(n_sdr - g0), 24'h000000);
    wr(`ADDR_ID_STROBE, 24'h000002);
    check("dig reset", 24'(n_sdr - g0), 24'h000001);
    wr(`ADDR_ID_STROBE, 24'h000000);
    check("temp held", 24'(n_temp), 24'h000001);
    wr(`ADDR_ID_STROBE, 24'h000001);
    rd_chk("enable reset", `ADDR_EN_RESET, 24'h00DF7F);
    rd_chk("cfg reset", `ADDR_LKD_CFG, 24'h07912A);
    done("strobes");
    end_of_test();
  end
endmodule // tb
